// ### hw/ber_pkg.sv
// Shared constants and types for the bit-error-rate measurement controller
package ber_pkg;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CFG = 8'h04;
	localparam logic [7:0] ADDR_BIT_TGT = 8'h08;
	localparam logic [7:0] ADDR_ERR_TGT = 8'h0C;
	localparam logic [7:0] ADDR_INTF = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_RX_BITS = 8'h18;
	localparam logic [7:0] ADDR_ERR_BITS = 8'h1C;
	localparam logic [7:0] ADDR_DROPS = 8'h20;
	localparam logic [7:0] ADDR_TOTAL = 8'h24;
	localparam logic [7:0] ADDR_ERR_TOTAL = 8'h28;
	// ----------------------------------------
	// Control bit positions
	// ----------------------------------------
	localparam int CTRL_START = 0;
	localparam int CTRL_STOP = 1;
	localparam int CTRL_CLEAR = 2;
	// ----------------------------------------
	// Modes and responses
	// ----------------------------------------
	localparam logic [1:0] MODE_CONT = 2'h0;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	localparam logic [1:0] MODE_ENDLESS = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// Limits and reset values
	// ----------------------------------------
	localparam logic [31:0] BITS_MAX = 32'hFFFFFFFF;
	localparam logic [15:0] DROPS_MAX = 16'hFFFF;
	localparam logic [15:0] WIN_500 = 16'h01F4;
	localparam logic [15:0] WIN_5000 = 16'h1388;
	localparam logic [15:0] WIN_50000 = 16'hC350;
	localparam logic [4:0] LOCK_RUN = 5'h12;
	localparam logic [31:0] BIT_TGT_RESET = 32'h000003E8;
	localparam logic [31:0] ERR_TGT_RESET = 32'h00000001;
	localparam logic [21:0] CFG_RESET = 22'h006419;
	localparam logic [1:0] INTF_RESET = 2'h0;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [14:0] thresh;
		logic [1:0] win_sel;
		logic drop_clear;
		logic auto_resync;
		logic count_err;
		logic [1:0] mode;
	} cfg_t;
	typedef struct packed {
		logic fall_edge;
		logic invert;
	} input_interface_settings_t;
	typedef struct packed {
		logic valid;
		logic data;
	} ser_bit_t;
endpackage

// ### hw/link_sampler.sv
// Samples the serial clock and data pins and emits one bit per selected edge
`timescale 1ns/100ps
module link_sampler (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire ber_pkg::input_interface_settings_t intf,
	output ber_pkg::ser_bit_t bit_o
);
	import ber_pkg::*;
	logic [1:0] clk_sync;
	logic [1:0] data_sync;
	logic clk_prev;
	logic data_prev;
	wire rise = clk_sync[1] & ~clk_prev;
	wire fall = ~clk_sync[1] & clk_prev;
	wire take = intf.fall_edge ? fall : rise;
	// Data delayed one more stage so it lines up with the edge detector
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_sync <= 2'h0;
			data_sync <= 2'h0;
			clk_prev <= 1'b0;
			data_prev <= 1'b0;
			bit_o <= '0;
		end else begin
			clk_sync <= {clk_sync[0], ser_clk};
			data_sync <= {data_sync[0], ser_data};
			clk_prev <= clk_sync[1];
			data_prev <= data_sync[1];
			bit_o.valid <= take;
			bit_o.data <= data_prev ^ intf.invert;
		end
	end
endmodule

// ### hw/prbs_checker.sv
// Self-synchronising nine-stage PRBS checker with lock detection
`timescale 1ns/100ps
module prbs_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire ber_pkg::ser_bit_t bit_i,
	input wire logic resync,
	output logic tick,
	output logic err,
	output logic locked
);
	import ber_pkg::*;
	logic [8:0] shreg;
	logic [4:0] run;
	wire pred = shreg[8] ^ shreg[4];
	wire miss = bit_i.data ^ pred;
	// Once locked, feed the prediction back so one bad bit is not repeated
	wire next_in = locked ? pred : bit_i.data;
	always_ff @(posedge aclk) begin
		if (!aresetn || resync) begin
			shreg <= 9'h000;
			run <= 5'h00;
			locked <= 1'b0;
			tick <= 1'b0;
			err <= 1'b0;
		end else begin
			tick <= bit_i.valid & locked;
			err <= bit_i.valid & locked & miss;
			if (bit_i.valid) begin
				shreg <= {shreg[7:0], next_in};
				run <= miss ? 5'h00 : run + 5'h01;
				if (!locked && !miss && run == LOCK_RUN - 5'h01) begin
					locked <= 1'b1;
				end
			end
		end
	end
endmodule

// ### hw/ber_meas_ctrl.sv
// Bit-error-rate measurement run control with AXI4-Lite register access
// Behaviour
// [RL1] Continuous mode: on termination, stop and immediately start a new run.
// [RL2] Changing any measurement setting stops the run; input interface changes do not.
// [RL3] Continuous mode publishes counts only at the end of each run.
// [RL4] Single and Endless update counts live and freeze them at completion.
// [RL5] Count-clear is ignored while Continuous mode is selected.
// [RL6] Clear while running zeroes reported counts, keeps sync; run ends on totals.
// [RL7] Clear while stopped zeroes received bits, error rate and progress.
// [RL8] Automatic relock on: watch for lock loss and resynchronise.
// [RL9] Automatic relock off: never check lock loss; keep measuring.
// [RL10] Lock loss is X errors within a Y-bit window; Y is 500/5000/50000.
// [RL11] Threshold and on-drop action act only with automatic relock on.
// [RL12] On lock drop, either zero or keep the measurement bit count.
// [RL13] Errors exceeding threshold while measuring stop measuring and resynchronise.
// [RL14] Every run first acquires sync; counting starts only once locked.
// [RL15] After power returns the measurement stays stopped.
// [RL16] Operator picks 50/500 below 0.3 percent errors, else 200/500.
// [RL17] Operator enables relock when the source does not regenerate clock.
// [RL18] Endless mode measures 4294967295 bits, ignoring criterion and targets.
// [RL19] Bit-count termination ends the run when total bits reach target.
// [RL20] Error-count termination ends the run when total errors reach target.
// [RL21] Lock-drop counter counts each drop and clears at a new run.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
module ber_meas_ctrl #(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ser_clk,
	input wire logic ser_data
);
	import ber_pkg::*;

	typedef enum logic [1:0] {ST_STOP, ST_SYNC, ST_MEAS} run_state_t;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = val[8*i +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		logic [7:0] lo;
		lo = a[7:0];
		return (a >> 8) == '0 && lo[1:0] == 2'h0 && lo <= ADDR_ERR_TOTAL;
	endfunction

	function automatic logic [15:0] win_len(input logic [1:0] sel);
		case (sel)
			2'h1: return WIN_5000;
			2'h2: return WIN_50000;
			default: return WIN_500;
		endcase
	endfunction

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	run_state_t state;
	run_state_t next_state;
	cfg_t cfg;
	input_interface_settings_t intf;
	logic [31:0] bit_tgt;
	logic [31:0] err_tgt;
	logic [31:0] total_bits;
	logic [31:0] total_errs;
	logic [31:0] live_bits;
	logic [31:0] live_errs;
	logic [15:0] drops;
	logic [31:0] rep_bits;
	logic [31:0] rep_errs;
	logic [15:0] rep_drops;
	logic [15:0] win_cnt;
	logic [15:0] win_err;
	logic done;
	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	ser_bit_t ser_bit;
	logic tick;
	logic err;
	logic locked;

	// ----------------------------------------
	// Serial input and pattern checker
	// ----------------------------------------
	link_sampler i_link_sampler (
		.aclk(aclk),
		.aresetn(aresetn),
		.ser_clk(ser_clk),
		.ser_data(ser_data),
		.intf(intf),
		.bit_o(ser_bit)
	);

	wire resync = next_state == ST_SYNC && state != ST_SYNC;

	prbs_checker i_prbs_checker (
		.aclk(aclk),
		.aresetn(aresetn),
		.bit_i(ser_bit),
		.resync(resync),
		.tick(tick),
		.err(err),
		.locked(locked)
	);

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	wire do_write = aw_held && w_held && !s_axi_bvalid;
	wire [7:0] wa = aw_addr[7:0];
	wire wr_hit = addr_hit(aw_addr);
	wire wr_ctrl = do_write && wr_hit && wa == ADDR_CTRL;
	wire wr_cfg = do_write && wr_hit && wa == ADDR_CFG;
	wire wr_btgt = do_write && wr_hit && wa == ADDR_BIT_TGT;
	wire wr_etgt = do_write && wr_hit && wa == ADDR_ERR_TGT;
	wire wr_intf = do_write && wr_hit && wa == ADDR_INTF;
	wire [31:0] cfg_word = merge({10'h000, cfg}, w_data, w_strb);
	wire [31:0] intf_word = merge({30'h0, intf}, w_data, w_strb);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && !w_held) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Settings come up at defaults; reset never resumes a run
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg <= cfg_t'(CFG_RESET);
			intf <= input_interface_settings_t'(INTF_RESET);
			bit_tgt <= BIT_TGT_RESET;
			err_tgt <= ERR_TGT_RESET;
		end else begin
			if (wr_cfg) cfg <= cfg_t'(cfg_word[21:0]);
			if (wr_intf) intf <= input_interface_settings_t'(intf_word[1:0]);
			if (wr_btgt) bit_tgt <= merge(bit_tgt, w_data, w_strb);
			if (wr_etgt) err_tgt <= merge(err_tgt, w_data, w_strb);
		end
	end

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	wire start_req = wr_ctrl && w_strb[0] && w_data[CTRL_START];
	wire clear_req = wr_ctrl && w_strb[0] && w_data[CTRL_CLEAR];
	// Interface register is left out on purpose
	wire halt = (wr_ctrl && w_strb[0] && w_data[CTRL_STOP])
		|| wr_cfg || wr_btgt || wr_etgt; // see [RL2]
	wire is_cont = cfg.mode == MODE_CONT;
	wire is_endless = cfg.mode == MODE_ENDLESS;
	wire meas = state == ST_MEAS;
	// Threshold and drop action only matter with relock on
	wire watch = meas && cfg.auto_resync; // see [RL9] see [RL11]
	wire [15:0] win_err_inc = win_err + 16'h0001;
	wire lock_drop = watch && tick && err && win_err_inc > {1'b0, cfg.thresh}; // see [RL13]
	wire drop_zero = lock_drop && cfg.drop_clear; // see [RL12]
	wire end_endless = total_bits == BITS_MAX; // see [RL18]
	wire end_bits = !cfg.count_err && total_bits >= bit_tgt; // see [RL19]
	wire end_errs = cfg.count_err && (total_errs >= err_tgt || total_bits == BITS_MAX); // see [RL20]
	wire end_drops = cfg.auto_resync && drops == DROPS_MAX;
	wire run_end = meas && (is_endless ? end_endless : (end_bits || end_errs || end_drops));
	wire new_run = (state == ST_STOP && next_state == ST_SYNC)
		|| (run_end && is_cont && !halt);
	wire bit_inc = meas && tick && !lock_drop && !run_end; // see [RL14]
	wire err_inc = bit_inc && err;
	wire clr_ok = clear_req && !is_cont; // see [RL5]
	wire clr_stop = clr_ok && state == ST_STOP;
	wire clr_run = clr_ok && state != ST_STOP;

	always_comb begin
		next_state = state;
		case (state)
			ST_STOP: begin
				if (start_req && !halt) next_state = ST_SYNC; // see [RL14]
			end
			ST_SYNC: begin
				if (halt) next_state = ST_STOP;
				else if (locked) next_state = ST_MEAS;
			end
			ST_MEAS: begin
				if (halt) next_state = ST_STOP;
				else if (run_end) next_state = is_cont ? ST_SYNC : ST_STOP; // see [RL1]
				else if (lock_drop) next_state = ST_SYNC; // see [RL8]
			end
			default: next_state = ST_STOP;
		endcase
	end

	// Power-up lands in stop; nothing restarts by itself
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_STOP; // see [RL15]
			done <= 1'b0;
		end else begin
			state <= next_state;
			if (new_run) done <= 1'b0;
			else if (run_end && !is_cont) done <= 1'b1;
		end
	end

	// ----------------------------------------
	// Counters
	// ----------------------------------------
	// A bit arriving with a clear is counted after it, so no event is lost
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			total_bits <= 32'h00000000;
			total_errs <= 32'h00000000;
		end else begin
			total_bits <= ((new_run || clr_stop || drop_zero) ? 32'h00000000 : total_bits)
				+ {31'h0, bit_inc}; // see [RL7] see [RL6]
			total_errs <= (new_run ? 32'h00000000 : total_errs) + {31'h0, err_inc};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			live_bits <= 32'h00000000;
			live_errs <= 32'h00000000;
		end else begin
			live_bits <= ((new_run || clr_ok || drop_zero) ? 32'h00000000 : live_bits)
				+ {31'h0, bit_inc}; // see [RL6] see [RL7]
			live_errs <= ((new_run || clr_ok) ? 32'h00000000 : live_errs)
				+ {31'h0, err_inc};
		end
	end

	wire drop_inc = lock_drop && drops != DROPS_MAX;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drops <= 16'h0000;
		end else begin
			drops <= ((new_run || clr_run) ? 16'h0000 : drops)
				+ {15'h0, drop_inc}; // see [RL21] see [RL6]
		end
	end

	// Window restarts whenever measuring is not under way
	wire win_wrap = win_cnt + 16'h0001 == win_len(cfg.win_sel); // see [RL10]

	always_ff @(posedge aclk) begin
		if (!aresetn || !watch || lock_drop) begin
			win_cnt <= 16'h0000;
			win_err <= 16'h0000;
		end else if (tick) begin
			win_cnt <= win_wrap ? 16'h0000 : win_cnt + 16'h0001;
			win_err <= win_wrap ? 16'h0000 : win_err + {15'h0, err}; // see [RL10]
		end
	end

	// ----------------------------------------
	// Reported results
	// ----------------------------------------
	// Continuous latches once per run; the others track live counts
	wire publish = is_cont ? run_end : 1'b1; // see [RL3] see [RL4]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rep_bits <= 32'h00000000;
			rep_errs <= 32'h00000000;
			rep_drops <= 16'h0000;
		end else if (publish) begin
			rep_bits <= live_bits;
			rep_errs <= live_errs;
			rep_drops <= drops;
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	wire [7:0] ra = s_axi_araddr[7:0];
	wire rd_hit = addr_hit(s_axi_araddr);
	wire [31:0] status_word = {28'h0, done, locked, state};
	wire [31:0] rd_word =
		ra == ADDR_CFG ? {10'h000, cfg} :
		ra == ADDR_BIT_TGT ? bit_tgt :
		ra == ADDR_ERR_TGT ? err_tgt :
		ra == ADDR_INTF ? {30'h0, intf} :
		ra == ADDR_STATUS ? status_word :
		ra == ADDR_RX_BITS ? rep_bits :
		ra == ADDR_ERR_BITS ? rep_errs :
		ra == ADDR_DROPS ? {16'h0000, rep_drops} :
		ra == ADDR_TOTAL ? total_bits :
		ra == ADDR_ERR_TOTAL ? total_errs : 32'h00000000;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_hit ? rd_word : 32'h00000000;
			s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ### tb/ber_link_model.sv
// PN9 serial source standing in for the device under test
`timescale 1ns/100ps
module ber_link_model #(
	parameter real HALF_NS = 100.0
) (
	input wire logic run,
	output logic ser_clk,
	output logic ser_data
);
	logic [8:0] lfsr;
	logic nb;
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		lfsr = 9'h1FF;
	end
	// New bit on the falling edge so it is settled at the rising one
	always begin
		#(HALF_NS);
		if (run) begin
			ser_clk = ~ser_clk;
			if (!ser_clk) begin
				nb = lfsr[8] ^ lfsr[4];
				lfsr = {lfsr[7:0], nb};
				ser_data = nb;
			end
		end else begin
			// Idle: clock still, data toggles so no stale bit looks valid
			ser_clk = 1'b0;
			ser_data = ~ser_data;
		end
	end
endmodule

// ### tb/ber_meas_ctrl_checker.sv
// Concurrent checks on the register-bus ports of the measurement controller
`timescale 1ns/100ps
module ber_meas_ctrl_checker #(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import ber_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_RST_IDLE: assert property (disable iff (1'b0) !aresetn |=>
		!s_axi_bvalid && !s_axi_rvalid && s_axi_arready) else $error("bus busy after reset");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while busy");
	AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	// Both halves are held first, the response follows one edge later
	AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
	AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr > ADDR_ERR_TOTAL |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 0)
		else $error("unmapped read not refused");
	AST_STATE_OK: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr == ADDR_STATUS |=> s_axi_rdata[1:0] != 2'h3) else $error("bad state");
	cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_STATUS
		##1 s_axi_rdata[1:0] == 2'h1);
endmodule
bind ber_meas_ctrl ber_meas_ctrl_checker #(.ADDR_W(ADDR_W)) i_ber_meas_ctrl_checker (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready)
);

// ### tb/ber_meas_ctrl_tb_top.sv
// Self-checking bench for the measurement controller
`timescale 1ns/100ps
module ber_meas_ctrl_tb_top;
	import ber_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic run = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] d, rdata;
	logic awready, wready, bvalid, arready, rvalid, ser_clk, ser_data;
	logic [1:0] bresp, rresp, rsp;
	int n_fail = 0;
	int comparisons = 0;
	always #12.5 aclk = ~aclk;
	ber_meas_ctrl i_ber_meas_ctrl (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ser_clk(ser_clk), .ser_data(ser_data));
	ber_link_model i_ber_link_model (.run(run), .ser_clk(ser_clk), .ser_data(ser_data));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Ready is register-driven, so its level at the falling edge holds to the next rise
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw, w;
		int t;
		@(posedge aclk);
		aw = 1'b0;
		w = 1'b0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (t = 0; t < 100 && !(aw && w); t++) begin
			@(negedge aclk);
			aw = aw | awready;
			w = w | wready;
			@(posedge aclk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end
		aw = 1'b0;
		for (t = 0; t < 100 && !aw; t++) begin
			@(negedge aclk);
			aw = bvalid;
			rsp = bresp;
			@(posedge aclk);
		end
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		logic k;
		int t;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		k = 1'b0;
		for (t = 0; t < 100 && !k; t++) begin
			@(negedge aclk);
			k = arready;
			@(posedge aclk);
		end
		arvalid <= 1'b0;
		k = 1'b0;
		for (t = 0; t < 100 && !k; t++) begin
			@(negedge aclk);
			k = rvalid;
			v = rdata;
			rsp = rresp;
			@(posedge aclk);
		end
		rready <= 1'b0;
	endtask
	task automatic poll(input logic [31:0] m, input logic [31:0] e);
		for (int t = 0; t < 5000; t++) begin
			rd(ADDR_STATUS, d);
			if ((d & m) == e) break;
		end
		chk(d & m, e);
	endtask
	task automatic complete_run;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Runs need about 40k cycles; twice that means a hang
	initial begin
		#2000000;
		n_fail++;
		complete_run;
	end
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		run <= 1'b1;
		rd(ADDR_STATUS, d);
		chk(d & 32'h3, 32'h0);
		rd(ADDR_CFG, d);
		chk(d, 32'(CFG_RESET));
		rd(8'h2C, d);
		chk(32'(rsp), 32'(RESP_SLVERR));
		wr(8'h2C, 32'h1);
		chk(32'(rsp), 32'(RESP_SLVERR));
		wr(ADDR_CTRL, 32'h1);
		chk(32'(rsp), 32'(RESP_OKAY));
		poll(32'h3, 32'h2);
		repeat (100) @(posedge aclk);
		rd(ADDR_RX_BITS, d);
		chk(32'(d != 0), 32'h1);
		poll(32'hB, 32'h8);
		rd(ADDR_TOTAL, d);
		chk(d, 32'h3E8);
		rd(ADDR_RX_BITS, d);
		chk(d, 32'h3E8);
		rd(ADDR_ERR_BITS, d);
		chk(d, 32'h0);
		wr(ADDR_CTRL, 32'h4);
		rd(ADDR_RX_BITS, d);
		chk(d, 32'h0);
		rd(ADDR_TOTAL, d);
		chk(d, 32'h0);
		wr(ADDR_BIT_TGT, 32'h7D0);
		wr(ADDR_CTRL, 32'h1);
		poll(32'h3, 32'h2);
		repeat (2000) @(posedge aclk);
		wr(ADDR_CTRL, 32'h4);
		rd(ADDR_RX_BITS, d);
		chk(32'(d < 32'h20), 32'h1);
		poll(32'hB, 32'h8);
		rd(ADDR_TOTAL, d);
		chk(d, 32'h7D0);
		rd(ADDR_RX_BITS, d);
		chk(32'(d < 32'h7D0 && d > 32'h3E8), 32'h1);
		// More errors than the threshold, so relock off must not stop
		wr(ADDR_CFG, 32'h6405);
		wr(ADDR_ERR_TGT, 32'h12C);
		wr(ADDR_CTRL, 32'h1);
		poll(32'h3, 32'h2);
		wr(ADDR_INTF, 32'h2);
		poll(32'hB, 32'h8);
		rd(ADDR_ERR_TOTAL, d);
		chk(d, 32'h12C);
		rd(ADDR_DROPS, d);
		chk(d, 32'h0);
		wr(ADDR_INTF, 32'h0);
		wr(ADDR_CFG, 32'h6419);
		wr(ADDR_BIT_TGT, 32'h000F4240);
		wr(ADDR_CTRL, 32'h1);
		poll(32'h3, 32'h2);
		wr(ADDR_INTF, 32'h2);
		poll(32'h3, 32'h1);
		rd(ADDR_DROPS, d);
		chk(d, 32'h1);
		rd(ADDR_TOTAL, d);
		chk(d, 32'h0);
		wr(ADDR_INTF, 32'h0);
		poll(32'h3, 32'h2);
		wr(ADDR_CTRL, 32'h2);
		poll(32'h3, 32'h0);
		wr(ADDR_CTRL, 32'h1);
		rd(ADDR_DROPS, d);
		chk(d, 32'h0);
		wr(ADDR_BIT_TGT, 32'h3E8);
		rd(ADDR_STATUS, d);
		chk(d & 32'h3, 32'h0);
		wr(ADDR_CTRL, 32'h4);
		rd(ADDR_RX_BITS, d);
		chk(d, 32'h0);
		wr(ADDR_CFG, 32'h6418);
		wr(ADDR_CTRL, 32'h1);
		poll(32'h3, 32'h2);
		repeat (3000) @(posedge aclk);
		rd(ADDR_RX_BITS, d);
		chk(d, 32'h0);
		wr(ADDR_CTRL, 32'h4);
		repeat (6000) @(posedge aclk);
		rd(ADDR_RX_BITS, d);
		chk(d, 32'h3E8);
		rd(ADDR_STATUS, d);
		chk(32'((d & 32'h3) != 0), 32'h1);
		wr(ADDR_CFG, 32'h6418);
		rd(ADDR_STATUS, d);
		chk(d & 32'h3, 32'h0);
		// Reset in mid-run: the run must not come back by itself
		wr(ADDR_CTRL, 32'h1);
		poll(32'h3, 32'h2);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (500) @(posedge aclk);
		rd(ADDR_STATUS, d);
		chk(d & 32'h3, 32'h0);
		complete_run;
	end
endmodule
